// *** hdl/frmr_core.v ***
// fifo core: resets, mode latching, strobe ports, mark and retransmit
// What this block does
// - full init resets pointers and level flags
// - full init latches fall-through mode, sets flags
// - full init latches width, order, timing settings
// - output register clears on either init
// - both inits asynchronous; full init before writes
// - partial init resets pointers and level flags
// - partial init keeps mode, sets its flags
// - partial init keeps offset programming method
// - async write: strobe edge stores input bus
// - async write: full flag from both sides
// - async read: strobe edge reads next word
// - async read: standard only, async empty, oe
// - replay low resets read pointer to mark
// - standard: empty low while replay low
// - fall-through: replay end loads marked word
// - replay repeatable, always to same mark
// - mark edge records output word location
// - write pointer stops at marked location
// - read edge with mark low leaves retransmit
// - new mark replaces previous mark
// - mark needs empty high or output-ready low
`timescale 1ns/1ps
`include "frmr_defs.vh"
module frmr_core (
  input wire clk_i,
  input wire rst_i,
  input wire full_init_n_i,
  input wire partial_init_n_i,
  input wire fall_through_serial_in_i,
  input wire async_write_select_n_i,
  input wire async_read_select_n_i,
  input wire output_width_sel_i,
  input wire input_width_sel_i,
  input wire byte_order_n_i,
  input wire prog_method_sel_i,
  input wire flag_timing_sel_i,
  input wire parity_layout_sel_i,
  input wire write_clk_i,
  input wire write_en_n_i,
  input wire [`FRMR_DATA_W-1:0] input_bus_i,
  input wire read_clk_i,
  input wire read_en_n_i,
  input wire read_select_n_i,
  input wire output_en_n_i,
  input wire mark_i,
  input wire replay_n_i,
  output reg [`FRMR_DATA_W-1:0] output_bus_o,
  output wire [`FRMR_DATA_W-1:0] output_bus_oe_n_o,
  output reg empty_flag_n_o,
  output reg full_flag_n_o,
  output reg almost_empty_n_o,
  output reg almost_full_n_o,
  output reg half_full_n_o,
  output wire fall_through_mode_o,
  output wire async_write_o,
  output wire async_read_o,
  output wire [`FRMR_CFG_W-1:0] config_o,
  output wire retransmit_o
);
  // pins from outside clk_i: two flops before use
  wire wclk_rise;
  wire rclk_rise;
  wire wen_n_s;
  wire ren_n_s;
  wire rcs_n_s;
  wire oe_n_s;
  wire mark_s;
  wire rt_n_s;
  wire [`FRMR_DATA_W-1:0] din_s;
  wire [`FRMR_CFG_W+2:0] strap_s;
  wire full_init;
  wire part_init;
  wire any_init;
  wire arst;
  frmr_sync u_wclk (.clk_i(clk_i), .rst_i(rst_i), .d_i(write_clk_i),
    .q_o(), .rise_o(wclk_rise), .fall_o());
  frmr_sync u_rclk (.clk_i(clk_i), .rst_i(rst_i), .d_i(read_clk_i),
    .q_o(), .rise_o(rclk_rise), .fall_o());
  reg [`FRMR_DATA_W+`FRMR_CFG_W+8:0] pin_s1;
  reg [`FRMR_DATA_W+`FRMR_CFG_W+8:0] pin_s2;
  wire [`FRMR_DATA_W+`FRMR_CFG_W+8:0] pin_raw;
  // two pad bits keep the six straps at cfg bits 6..1
  assign pin_raw = {
    input_bus_i,
    write_en_n_i,
    read_en_n_i,
    read_select_n_i,
    output_en_n_i,
    mark_i,
    replay_n_i,
    fall_through_serial_in_i,
    async_write_select_n_i,
    async_read_select_n_i,
    output_width_sel_i,
    input_width_sel_i,
    byte_order_n_i,
    prog_method_sel_i,
    flag_timing_sel_i,
    parity_layout_sel_i,
    1'b0,
    1'b0};
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= {(`FRMR_DATA_W+`FRMR_CFG_W+9){1'b0}};
      pin_s2 <= {(`FRMR_DATA_W+`FRMR_CFG_W+9){1'b0}};
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end
  assign din_s = pin_s2[`FRMR_DATA_W+`FRMR_CFG_W+8:`FRMR_CFG_W+9];
  assign wen_n_s = pin_s2[`FRMR_CFG_W+8];
  assign ren_n_s = pin_s2[`FRMR_CFG_W+7];
  assign rcs_n_s = pin_s2[`FRMR_CFG_W+6];
  assign oe_n_s = pin_s2[`FRMR_CFG_W+5];
  assign mark_s = pin_s2[`FRMR_CFG_W+4];
  assign rt_n_s = pin_s2[`FRMR_CFG_W+3];
  assign strap_s = pin_s2[`FRMR_CFG_W+2:0];

  // inits assert at once, release through a synchroniser
  frmr_rst_sync u_full (.clk_i(clk_i), .rst_i(rst_i),
    .init_n_i(full_init_n_i), .init_o(full_init));
  frmr_rst_sync u_part (.clk_i(clk_i), .rst_i(rst_i),
    .init_n_i(partial_init_n_i), .init_o(part_init));
  assign any_init = full_init | part_init;
  assign arst = rst_i;

  // straps: caught by clock while full init is held, kept afterwards
  reg fall_through_mode;
  reg async_write_select_n;
  reg async_read_select_n;
  reg [`FRMR_CFG_W-1:0] cfg;
  always @(posedge clk_i or posedge arst) begin
    if (arst) begin
      fall_through_mode <= 1'b0;
      async_write_select_n <= 1'b0;
      async_read_select_n <= 1'b0;
      cfg <= `FRMR_CFG_RST;
    end else if (full_init) begin
      // fall-through is refused with either async port
      fall_through_mode <= strap_s[`FRMR_CFG_W+2] & strap_s[`FRMR_CFG_W+1]
        & strap_s[`FRMR_CFG_W];
      async_write_select_n <= ~strap_s[`FRMR_CFG_W+1];
      async_read_select_n <= ~strap_s[`FRMR_CFG_W];
      cfg <= {1'b0, strap_s[`FRMR_CFG_W-1:1]};
    end
  end
  assign fall_through_mode_o = fall_through_mode;
  assign async_write_o = async_write_select_n;
  assign async_read_o = async_read_select_n;
  assign config_o = cfg;

  // storage and pointers
  reg [`FRMR_DATA_W-1:0] mem [0:`FRMR_DEPTH-1];
  reg [`FRMR_ADDR_W:0] wptr;
  reg [`FRMR_ADDR_W:0] rptr;
  reg [`FRMR_ADDR_W:0] mark_ptr;
  reg [`FRMR_ADDR_W:0] out_ptr;
  reg rtx_mode;
  reg replaying;
  reg fall_through_mode_valid;
  wire [`FRMR_ADDR_W:0] level;
  wire empty;
  wire full;
  wire mark_block;
  // gap kept at pointer width so the wrap is modulo twice the depth
  wire [`FRMR_ADDR_W:0] mark_gap;
  assign mark_gap = wptr - mark_ptr;
  assign level = wptr - rptr;
  assign empty = (level == {(`FRMR_ADDR_W+1){1'b0}});
  assign full = (level[`FRMR_ADDR_W] == 1'b1);
  // writer may not pass the marked word while retransmit holds
  assign mark_block = rtx_mode &&
    (mark_gap == `FRMR_DEPTH);

  // write port: strobe ignores enable, clock mode honours it
  wire do_write;
  assign do_write = wclk_rise && !full && !mark_block &&
    (async_write_select_n || !wen_n_s);
  always @(posedge clk_i) begin
    if (do_write) begin
      mem[wptr[`FRMR_ADDR_W-1:0]] <= din_s;
    end
  end
  always @(posedge clk_i or posedge arst) begin
    if (arst) begin
      wptr <= {1'b0, `FRMR_PTR_RST};
    end else if (any_init) begin
      wptr <= {1'b0, `FRMR_PTR_RST};
    end else if (do_write) begin
      wptr <= wptr + 1'b1;
    end
  end

  // read port
  wire rd_req;
  wire do_read;
  wire fall_load;
  wire rt_edge;
  wire mark_edge;
  wire can_mark;
  assign rd_req = async_read_select_n || (!ren_n_s && !rcs_n_s);
  assign rt_edge = rclk_rise && rtx_mode && !rt_n_s;
  // standard mode needs a word present, fall-through a word shown
  assign can_mark = fall_through_mode ? fall_through_mode_valid : !empty;
  assign mark_edge = rclk_rise && mark_s && !rtx_mode && can_mark;
  // word falls through to output without a read request
  assign fall_load = rclk_rise && fall_through_mode && !fall_through_mode_valid && !empty &&
    !rt_edge && !replaying;
  assign do_read = rclk_rise && rd_req && !empty && !replaying &&
    !rt_edge && !fall_load && (!fall_through_mode || fall_through_mode_valid);
  always @(posedge clk_i or posedge arst) begin
    if (arst) begin
      rptr <= {1'b0, `FRMR_PTR_RST};
      out_ptr <= {1'b0, `FRMR_PTR_RST};
      mark_ptr <= {1'b0, `FRMR_PTR_RST};
      rtx_mode <= 1'b0;
      replaying <= 1'b0;
      fall_through_mode_valid <= 1'b0;
      output_bus_o <= `FRMR_OUT_RST;
    end else if (any_init) begin
      rptr <= {1'b0, `FRMR_PTR_RST};
      out_ptr <= {1'b0, `FRMR_PTR_RST};
      mark_ptr <= {1'b0, `FRMR_PTR_RST};
      rtx_mode <= 1'b0;
      replaying <= 1'b0;
      fall_through_mode_valid <= 1'b0;
      output_bus_o <= `FRMR_OUT_RST;
    end else begin
      if (rclk_rise && !mark_s) begin
        rtx_mode <= 1'b0;
      end else if (mark_edge) begin
        mark_ptr <= out_ptr;
        rtx_mode <= 1'b1;
      end
      if (rt_edge) begin
        rptr <= mark_ptr;
        replaying <= 1'b1;
        fall_through_mode_valid <= 1'b0;
      end else if (rclk_rise && replaying) begin
        // replay ends on first edge after replay input rises
        replaying <= 1'b0;
        if (fall_through_mode) begin
          output_bus_o <= mem[rptr[`FRMR_ADDR_W-1:0]];
          out_ptr <= rptr;
          rptr <= rptr + 1'b1;
          fall_through_mode_valid <= 1'b1;
        end
      end else if (fall_load || do_read) begin
        output_bus_o <= mem[rptr[`FRMR_ADDR_W-1:0]];
        out_ptr <= rptr;
        rptr <= rptr + 1'b1;
        fall_through_mode_valid <= 1'b1;
      end else if (rclk_rise && fall_through_mode && rd_req && fall_through_mode_valid) begin
        fall_through_mode_valid <= 1'b0;
      end
    end
  end
  assign retransmit_o = rtx_mode;

  // output drive: oe low drives the bus; in clocked read mode read select must also be low (enable low = driving)
  assign output_bus_oe_n_o = {`FRMR_DATA_W{
    async_read_select_n ? oe_n_s : (oe_n_s | rcs_n_s)}};

  // mode for the init flags: the strap itself while full init latches it
  wire init_ft;
  assign init_ft = full_init ? (strap_s[`FRMR_CFG_W+2] &
    strap_s[`FRMR_CFG_W+1] & strap_s[`FRMR_CFG_W]) : fall_through_mode;

  // flags; async ports update from either side on every cycle
  always @(posedge clk_i or posedge arst) begin
    if (arst) begin
      empty_flag_n_o <= 1'b0;
      full_flag_n_o <= 1'b1;
      almost_empty_n_o <= 1'b0;
      almost_full_n_o <= 1'b1;
      half_full_n_o <= 1'b1;
    end else if (any_init) begin
      almost_empty_n_o <= 1'b0;
      almost_full_n_o <= 1'b1;
      half_full_n_o <= 1'b1;
      empty_flag_n_o <= init_ft;
      full_flag_n_o <= ~init_ft;
    end else begin
      almost_empty_n_o <= (level > `FRMR_AE_OFS);
      almost_full_n_o <= (level < `FRMR_AF_OFS);
      half_full_n_o <= (level <= `FRMR_HALF);
      if (fall_through_mode) begin
        // output-ready low when a word is shown
        empty_flag_n_o <= replaying | rt_edge | !fall_through_mode_valid;
        full_flag_n_o <= full | mark_block;
      end else begin
        empty_flag_n_o <= !(empty | replaying | rt_edge);
        full_flag_n_o <= !(full | mark_block);
      end
    end
  end
endmodule

// *** hdl/frmr_defs.vh ***
// constants shared by the fifo reset, mode and retransmit control core
`ifndef FRMR_DEFS_VH
`define FRMR_DEFS_VH
`define FRMR_DATA_W 18
`define FRMR_ADDR_W 6
`define FRMR_DEPTH 64
`define FRMR_PTR_RST 6'h00
`define FRMR_OUT_RST 18'h00000
`define FRMR_CFG_W 8
`define FRMR_CFG_RST 8'h00
`define FRMR_HALF 7'h20
`define FRMR_AE_OFS 7'h08
`define FRMR_AF_OFS 7'h38
`endif

// *** hdl/frmr_rst_sync.v ***
// reset combiner: asynchronous assert, synchronised release
`timescale 1ns/1ps
`include "frmr_defs.vh"
module frmr_rst_sync (
  input wire clk_i,
  input wire rst_i,
  input wire init_n_i,
  output wire init_o
);
  reg r1;
  reg r2;
  wire arst;
  assign arst = rst_i | ~init_n_i;
  always @(posedge clk_i or posedge arst) begin
    if (arst) begin
      r1 <= 1'b1;
      r2 <= 1'b1;
    end else begin
      r1 <= 1'b0;
      r2 <= r1;
    end
  end
  assign init_o = r2;
endmodule

// *** hdl/frmr_sync.v ***
// two-flop synchroniser with edge detection for pins from outside clk_i
`timescale 1ns/1ps
`include "frmr_defs.vh"
module frmr_sync (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output wire q_o,
  output wire rise_o,
  output wire fall_o
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign q_o = s2;
  assign rise_o = s2 & ~s3;
  assign fall_o = ~s2 & s3;
endmodule

// *** verif/frmr_core_sva.sv ***
// port assertions for the fifo control core
`timescale 1ns/1ps
`include "frmr_defs.vh"
module frmr_core_sva (
  input wire clk_i,
  input wire rst_i,
  input wire full_init_n_i,
  input wire partial_init_n_i,
  input wire fall_through_serial_in_i,
  input wire async_write_select_n_i,
  input wire async_read_select_n_i,
  input wire mark_i,
  input wire replay_n_i,
  input wire output_en_n_i,
  input wire [`FRMR_DATA_W-1:0] output_bus_o,
  input wire [`FRMR_DATA_W-1:0] output_bus_oe_n_o,
  input wire empty_flag_n_o,
  input wire full_flag_n_o,
  input wire almost_empty_n_o,
  input wire almost_full_n_o,
  input wire half_full_n_o,
  input wire fall_through_mode_o,
  input wire [`FRMR_CFG_W-1:0] config_o,
  input wire retransmit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire init = !full_init_n_i || !partial_init_n_i;
  wire ft_req = fall_through_serial_in_i && async_write_select_n_i &&
    async_read_select_n_i;
  wire rpl = retransmit_o && !replay_n_i;
  property p_init_lvl;
    init [*2] |-> !almost_empty_n_o && almost_full_n_o && half_full_n_o;
  endproperty
  a_init_lvl: assert property (p_init_lvl)
    else $error("level flags not reset");
  property p_init_out;
    init [*2] |-> output_bus_o == `FRMR_OUT_RST;
  endproperty
  a_init_out: assert property (p_init_out)
    else $error("output word not cleared");
  property p_init_mode;
    init [*3] |-> empty_flag_n_o == fall_through_mode_o &&
      full_flag_n_o != fall_through_mode_o;
  endproperty
  a_init_mode: assert property (p_init_mode)
    else $error("mode flags wrong in init");
  // straps must be held until the synchronised release
  property p_strap;
    !full_init_n_i [*4] ##1 full_init_n_i [*4] |->
      fall_through_mode_o == $past(ft_req, 4);
  endproperty
  a_strap: assert property (p_strap)
    else $error("mode not latched from straps");
  property p_cfg_hold;
    full_init_n_i [*4] |-> $stable({config_o, fall_through_mode_o});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("settings changed outside full init");
  property p_mark_entry;
    $rose(retransmit_o) |-> mark_i &&
      $past(empty_flag_n_o) != $past(fall_through_mode_o);
  endproperty
  a_mark_entry: assert property (p_mark_entry)
    else $error("retransmit entered without mark");
  property p_replay_flag;
    rpl [*8] ##1 rpl [*8] |-> empty_flag_n_o == fall_through_mode_o;
  endproperty
  a_replay_flag: assert property (p_replay_flag)
    else $error("flag wrong while replaying");
  property p_oe_off;
    output_en_n_i [*4] |-> &output_bus_oe_n_o;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output driven with enable off");
  c_replay: cover property (rpl);
  c_mark: cover property ($rose(retransmit_o));
  c_part: cover property (!partial_init_n_i && full_init_n_i);
endmodule
bind frmr_core frmr_core_sva u_sva (.*);

// *** verif/frmr_partner.sv ***
// writer and reader clocks that run only within a frame
`timescale 1ns/1ps
module frmr_partner (
  input wire run_w_i,
  input wire run_r_i,
  output reg wclk_o,
  output reg rclk_o
);
  // odd offsets keep both unrelated to the core clock; idle low
  initial begin
    wclk_o = 1'b0;
    #137;
    forever #400 wclk_o = run_w_i ? ~wclk_o : 1'b0;
  end
  initial begin
    rclk_o = 1'b0;
    #251;
    forever #400 rclk_o = run_r_i ? ~rclk_o : 1'b0;
  end
endmodule

// *** verif/tb_frmr_core.sv ***
// self-checking bench for the fifo control core
`timescale 1ns/1ps
`include "frmr_defs.vh"
module tb_frmr_core;
  reg clk_i = 0, rst_i = 1, full_n = 0, part_n = 1, oe_n = 1, wen_n = 1;
  reg ren_n = 1, mark = 0, rt_n = 1, run_w = 0, run_r = 0, ft = 0;
  wire [17:0] oe_q;
  reg [5:0] straps = 0;
  reg [17:0] din = 0, st = 18'h00060;
  reg [17:0] exp_q[$];
  wire wclk, rclk, ef_n, ff_n, ae_n, af_n, hf_n, ftm, rtx;
  wire [17:0] q;
  wire [7:0] cfg;
  integer n_errors = 0, samples_checked = 0, i, k, m, rp = 0;
  frmr_partner u_far (.run_w_i(run_w), .run_r_i(run_r), .wclk_o(wclk),
    .rclk_o(rclk));
  frmr_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .full_init_n_i(full_n),
    .partial_init_n_i(part_n), .fall_through_serial_in_i(ft),
    .async_write_select_n_i(1'b1), .async_read_select_n_i(1'b1),
    .output_width_sel_i(straps[5]), .input_width_sel_i(straps[4]),
    .byte_order_n_i(straps[3]), .prog_method_sel_i(straps[2]),
    .flag_timing_sel_i(straps[1]), .parity_layout_sel_i(straps[0]),
    .write_clk_i(wclk), .write_en_n_i(wen_n), .input_bus_i(din),
    .read_clk_i(rclk), .read_en_n_i(ren_n), .read_select_n_i(1'b0),
    .output_en_n_i(oe_n), .mark_i(mark), .replay_n_i(rt_n),
    .output_bus_o(q), .output_bus_oe_n_o(oe_q), .empty_flag_n_o(ef_n),
    .full_flag_n_o(ff_n), .almost_empty_n_o(ae_n), .almost_full_n_o(af_n),
    .half_full_n_o(hf_n), .fall_through_mode_o(ftm), .async_write_o(),
    .async_read_o(), .config_o(cfg), .retransmit_o(rtx));
  function [17:0] lfsr(input [17:0] s);
    lfsr = {s[16:0], s[17] ^ s[10]};
  endfunction
  function [2:0] lvl_flags(input integer n);
    lvl_flags = {n > `FRMR_AE_OFS, n < `FRMR_AF_OFS, n <= `FRMR_HALF};
  endfunction
  task check(input [17:0] got, input [17:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (got !== want) begin
        n_errors = n_errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task clks(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task rd(input integer n, input integer chk);
    begin
      run_r = 1;
      for (i = 0; i < n; i = i + 1) begin
        @(posedge rclk);
        if (i == n - 1) run_r = 0;
        // 2 cycles to detect the edge, 1 more for the word
        clks(6);
        if (chk) begin
          check(q, exp_q[rp]);
          rp = rp + 1;
        end
      end
      clks(4);
    end
  endtask
  initial forever #50 clk_i = ~clk_i;
  always @(negedge wclk) begin
    @(posedge clk_i);
    st = lfsr(st);
    din <= st;
  end
  always @(posedge wclk) if (!wen_n) exp_q.push_back(din);
  initial begin
    #(6000 * 100);
    n_errors = n_errors + 1;
    conclude;
  end
  initial begin
    straps = st[5:0];
    clks(5);
    @(posedge clk_i) rst_i <= 0;
    clks(6);
    check({ae_n, af_n, hf_n, ef_n, ff_n}, 5'h0d);
    check(q, `FRMR_OUT_RST);
    @(posedge clk_i) full_n <= 1;
    clks(6);
    check(cfg[6:1], straps);
    check(ftm, 1'b0);
    check(oe_q, 18'h3ffff);
    $display("init done");
    @(posedge clk_i) begin wen_n <= 0; oe_n <= 0; ren_n <= 0; end
    run_w = 1;
    repeat (40) @(posedge wclk);
    run_w = 0;
    clks(12);
    check({ae_n, af_n, hf_n}, lvl_flags(40));
    check({ef_n, ff_n}, 2'b11);
    check(oe_q, 18'h00000);
    rd(4, 1);
    $display("reads done");
    for (k = 0; k < 2; k = k + 1) begin
      @(posedge clk_i) begin ren_n <= 1; mark <= 1; end
      m = rp - 1;
      rd(2, 0);
      check(rtx, 1'b1);
      @(posedge clk_i) ren_n <= 0;
      rd(3, 1);
      repeat (2) begin
        @(posedge clk_i) begin ren_n <= 1; rt_n <= 0; end
        rd(2, 0);
        check(ef_n, 1'b0);
        @(posedge clk_i) rt_n <= 1;
        rd(1, 0);
        check(ef_n, 1'b1);
        @(posedge clk_i) ren_n <= 0;
        rp = m;
        rd(3, 1);
      end
      @(posedge clk_i) begin ren_n <= 1; mark <= 0; end
      rd(1, 0);
      check(rtx, 1'b0);
      $display("mark pass %0d done", k);
    end
    @(posedge clk_i) part_n <= 0;
    clks(6);
    check(q, `FRMR_OUT_RST);
    check({ae_n, af_n, hf_n, ef_n, ff_n}, 5'h0d);
    check(cfg[6:1], straps);
    @(posedge clk_i) part_n <= 1;
    clks(6);
    $display("partial init done");
    @(posedge clk_i) begin full_n <= 0; ft <= 1; end
    clks(6);
    check({ef_n, ff_n}, 2'b10);
    @(posedge clk_i) full_n <= 1;
    clks(6);
    check(ftm, 1'b1);
    rp = exp_q.size();
    run_w = 1;
    @(posedge wclk);
    run_w = 0;
    clks(12);
    rd(1, 1);
    check(ef_n, 1'b0);
    $display("fall-through done");
    conclude;
  end
endmodule
